/* File: design/tcv_top.sv */
`timescale 1ns/1ps
module tcv_top
  import tcv_pkg::*;
(
  // apb slave
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  // timer side
  input  wire logic [VAL_W-1:0]    counter,
  input  wire logic [NUM_CHAN-1:0] capture_event,
  input  wire logic [NUM_CHAN-1:0] compare_event,
  // results
  output logic [NUM_CHAN-1:0]      compare_match
);
  logic                       hit_value;
  logic [2:0]                 chan;
  logic                       is_high;
  logic                       hit_mode;
  logic                       hit_status;
  logic                       access;
  logic [MODE_W-1:0]          mode    [NUM_CHAN];
  logic [VAL_W-1:0]           value   [NUM_CHAN];
  logic [NUM_CHAN-1:0]        inhibit;
  logic [NUM_CHAN-1:0]        capmode;
  logic [NUM_CHAN-1:0]        match;
  logic [31:0]                next_prdata;

  assign access  = psel & penable;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  tcv_apb_decode u_dec (
    .paddr      (paddr),
    .hit_value  (hit_value),
    .chan       (chan),
    .is_high    (is_high),
    .hit_mode   (hit_mode),
    .hit_status (hit_status)
  );

  genvar g;
  generate
    for (g = 0; g < NUM_CHAN; g++) begin : g_ch
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mode[g] <= MODE_RESET;
        end else if (access && pwrite && hit_mode && chan == 3'(g)) begin
          mode[g] <= pwdata[MODE_W-1:0];
        end
      end
      tcv_channel u_ch (
        .pclk          (pclk),
        .presetn       (presetn),
        .mode          (mode[g]),
        .acc_en        (access && hit_value && chan == 3'(g)),
        .acc_write     (pwrite),
        .acc_high      (is_high),
        .wdata         (pwdata[BYTE_W-1:0]),
        .capture_event (capture_event[g]),
        .counter       (counter),
        .compare_event (compare_event[g]),
        .value         (value[g]),
        .inhibit       (inhibit[g]),
        .capture_mode  (capmode[g]),
        .compare_match (match[g])
      );
    end
  endgenerate

  always_comb begin
    next_prdata = UNMAPPED_READ;
    if (hit_value) begin
      next_prdata[BYTE_W-1:0] = is_high ? value[chan][VAL_W-1:BYTE_W]
                                        : value[chan][BYTE_W-1:0];
    end else if (hit_mode) begin
      next_prdata[MODE_W-1:0] = mode[chan];
    end else if (hit_status) begin
      next_prdata[NUM_CHAN-1:0] = inhibit;
    end
  end

  // read data registered in the setup cycle, valid during access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= UNMAPPED_READ;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_match <= '0;
    end else begin
      compare_match <= match;
    end
  end
endmodule

/* File: design/tcv_pkg.sv */
package tcv_pkg;
  // channel count and value width
  localparam int NUM_CHAN = 6;
  localparam int VAL_W = 16;
  localparam int BYTE_W = 8;
  // printed offsets are not all multiples of four: these are indices, byte address = 4 * index
  localparam logic [7:0] IDX_CHAN0_VALUE_HIGH = 8'h27;
  localparam logic [7:0] IDX_CHAN0_VALUE_LOW = 8'h28;
  localparam logic [7:0] IDX_CHAN1_VALUE_HIGH = 8'h2A;
  localparam logic [7:0] IDX_CHAN1_VALUE_LOW = 8'h2B;
  localparam logic [7:0] IDX_CHAN2_VALUE_HIGH = 8'h2D;
  localparam logic [7:0] IDX_CHAN2_VALUE_LOW = 8'h2E;
  localparam logic [7:0] IDX_CHAN3_VALUE_HIGH = 8'h30;
  localparam logic [7:0] IDX_CHAN3_VALUE_LOW = 8'h31;
  localparam logic [7:0] IDX_CHAN4_VALUE_HIGH = 8'h33;
  localparam logic [7:0] IDX_CHAN4_VALUE_LOW = 8'h34;
  localparam logic [7:0] IDX_CHAN5_VALUE_HIGH = 8'h36;
  localparam logic [7:0] IDX_CHAN5_VALUE_LOW = 8'h37;
  // per-channel mode register, index = IDX_MODE_BASE + channel
  localparam logic [7:0] IDX_MODE_BASE = 8'h40;
  // status register: inhibit bits, one per channel
  localparam logic [7:0] IDX_INHIBIT_STATUS = 8'h48;
  // mode register field positions
  localparam int MODE_ELS_LOW_BIT = 0;
  localparam int MODE_ELS_HIGH_BIT = 1;
  localparam int MODE_CAPCMP_BIT = 2;
  localparam int MODE_BUFFERED_BIT = 3;
  localparam int MODE_W = 4;
  localparam logic [MODE_W-1:0] MODE_RESET = 4'h0;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
  localparam logic [VAL_W-1:0] VALUE_INIT = 16'h0000;
  typedef enum logic [1:0] {
    tcv_seq_idle_e = 2'b01,
    tcv_seq_wait_low_e = 2'b10
  } tcv_seq_e;
endpackage

/* File: design/tcv_apb_decode.sv */
`timescale 1ns/1ps
module tcv_apb_decode
  import tcv_pkg::*;
(
  // apb address
  input  wire logic [11:0] paddr,
  // decode results
  output logic             hit_value,
  output logic [2:0]       chan,
  output logic             is_high,
  output logic             hit_mode,
  output logic             hit_status
);
  logic [9:0] idx;
  logic [7:0] i8;
  assign idx = paddr[11:2];
  assign i8  = idx[7:0];
  always_comb begin
    hit_value  = 1'b0;
    chan       = 3'd0;
    is_high    = 1'b0;
    hit_mode   = 1'b0;
    hit_status = 1'b0;
    if (paddr[1:0] == 2'b00 && idx[9:8] == 2'b00) begin
      unique case (i8)
        IDX_CHAN0_VALUE_HIGH: begin hit_value = 1'b1; chan = 3'd0; is_high = 1'b1; end
        IDX_CHAN0_VALUE_LOW:  begin hit_value = 1'b1; chan = 3'd0; end
        IDX_CHAN1_VALUE_HIGH: begin hit_value = 1'b1; chan = 3'd1; is_high = 1'b1; end
        IDX_CHAN1_VALUE_LOW:  begin hit_value = 1'b1; chan = 3'd1; end
        IDX_CHAN2_VALUE_HIGH: begin hit_value = 1'b1; chan = 3'd2; is_high = 1'b1; end
        IDX_CHAN2_VALUE_LOW:  begin hit_value = 1'b1; chan = 3'd2; end
        IDX_CHAN3_VALUE_HIGH: begin hit_value = 1'b1; chan = 3'd3; is_high = 1'b1; end
        IDX_CHAN3_VALUE_LOW:  begin hit_value = 1'b1; chan = 3'd3; end
        IDX_CHAN4_VALUE_HIGH: begin hit_value = 1'b1; chan = 3'd4; is_high = 1'b1; end
        IDX_CHAN4_VALUE_LOW:  begin hit_value = 1'b1; chan = 3'd4; end
        IDX_CHAN5_VALUE_HIGH: begin hit_value = 1'b1; chan = 3'd5; is_high = 1'b1; end
        IDX_CHAN5_VALUE_LOW:  begin hit_value = 1'b1; chan = 3'd5; end
        IDX_INHIBIT_STATUS:   hit_status = 1'b1;
        default: begin
          if (i8 >= IDX_MODE_BASE && i8 < IDX_MODE_BASE + 8'd6) begin
            hit_mode = 1'b1;
            chan     = 3'(i8 - IDX_MODE_BASE);
          end
        end
      endcase
    end
  end
endmodule

/* File: design/tcv_channel.sv */
`timescale 1ns/1ps
module tcv_channel
  import tcv_pkg::*;
(
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // mode bits
  input  wire logic [MODE_W-1:0] mode,
  // bus byte access for this channel
  input  wire logic              acc_en,
  input  wire logic              acc_write,
  input  wire logic              acc_high,
  input  wire logic [BYTE_W-1:0] wdata,
  // timer side
  input  wire logic              capture_event,
  input  wire logic [VAL_W-1:0]  counter,
  input  wire logic              compare_event,
  // results
  output logic [VAL_W-1:0]       value,
  output logic                   inhibit,
  output logic                   capture_mode,
  output logic                   compare_match
);
  tcv_seq_e   seq;
  tcv_seq_e   next_seq;
  logic       els_on;
  logic       open_acc;
  logic       close_acc;

  assign els_on = mode[MODE_ELS_HIGH_BIT] | mode[MODE_ELS_LOW_BIT];
  // input capture when both mode-select bits are clear
  assign capture_mode = ~mode[MODE_BUFFERED_BIT] & ~mode[MODE_CAPCMP_BIT];
  // capture: high read opens, low read closes; compare: high write opens, low write closes
  assign open_acc  = acc_en & acc_high & (acc_write != capture_mode);
  assign close_acc = acc_en & ~acc_high & (acc_write != capture_mode);
  assign inhibit   = (seq == tcv_seq_wait_low_e);

  always_comb begin
    next_seq = seq;
    unique case (seq)
      tcv_seq_idle_e:     if (open_acc) next_seq = tcv_seq_wait_low_e;
      tcv_seq_wait_low_e: if (close_acc) next_seq = tcv_seq_idle_e;
      default:            next_seq = tcv_seq_idle_e;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq <= tcv_seq_idle_e;
    end else begin
      seq <= next_seq;
    end
  end

  // value holds its contents over reset
  always_ff @(posedge pclk) begin
    if (acc_en && acc_write) begin
      if (acc_high) begin
        value[VAL_W-1:BYTE_W] <= wdata;
      end else begin
        value[BYTE_W-1:0] <= wdata;
      end
    end else if (capture_mode && els_on && capture_event && !inhibit) begin
      value <= counter;
    end
  end

  assign compare_match = ~capture_mode & els_on & compare_event & ~inhibit
                         & (counter == value);
endmodule

/* File: verif/tcv_monitor.sv */
`timescale 1ns/1ps
module tcv_monitor
  import tcv_pkg::*;
(
  // apb
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [11:0]         paddr,
  input wire logic [31:0]         pwdata,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  // timer
  input wire logic [VAL_W-1:0]    counter,
  input wire logic [NUM_CHAN-1:0] capture_event,
  input wire logic [NUM_CHAN-1:0] compare_event,
  input wire logic [NUM_CHAN-1:0] compare_match
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic        acc, hw, lw, wr, cmp, ld, inh;
  logic [3:0]  md;
  logic [15:0] v;
  // channel 0 shadow
  assign acc = psel & penable;
  assign hw = paddr == {2'b00, IDX_CHAN0_VALUE_HIGH, 2'b00};
  assign lw = paddr == {2'b00, IDX_CHAN0_VALUE_LOW, 2'b00};
  assign wr = acc & pwrite & (hw | lw);
  assign cmp = md[MODE_CAPCMP_BIT] | md[MODE_BUFFERED_BIT];
  assign ld = capture_event[0] & !cmp & md[1:0] != 2'b00 & !inh & !wr;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      md <= MODE_RESET;
      inh <= 1'b0;
    end else if (acc) begin
      if (pwrite & paddr == {2'b00, IDX_MODE_BASE, 2'b00}) md <= pwdata[3:0];
      if (hw & (pwrite == cmp)) inh <= 1'b1;
      if (lw & (pwrite == cmp)) inh <= 1'b0;
    end
  end
  always_ff @(posedge pclk) begin
    if (wr & hw) v[15:8] <= pwdata[7:0];
    else if (wr) v[7:0] <= pwdata[7:0];
    else if (ld) v <= counter;
  end
  AST_READ_HIGH: assert property (acc & !pwrite & hw |-> prdata == {24'h0, $past(v[15:8])})
    else $error("high byte read mismatch");
  AST_READ_LOW: assert property (acc & !pwrite & lw |-> prdata == {24'h0, $past(v[7:0])})
    else $error("low byte read mismatch");
  AST_CAP_LOAD: assert property (ld ##1 !(ld | wr) [*2] ##1 (acc & !pwrite & hw)
    |-> prdata[7:0] == $past(counter[15:8], 3)) else $error("capture not loaded");
  AST_CMP_FIRES: assert property (cmp & md[1:0] != 2'b00 & compare_event[0] & !inh
    & counter == v |=> compare_match[0]) else $error("compare match missing");
  AST_CMP_BLOCK: assert property (compare_match[0] |-> !$past(inh))
    else $error("match while inhibited");
  AST_MODE_PICK: assert property (compare_match[0] |-> $past(cmp))
    else $error("match in capture mode");
  AST_KEEP_RESET: assert property (acc & !pwrite & lw & !$past(presetn, 3)
    |-> prdata[7:0] == $past(v[7:0])) else $error("value lost over reset");
  cover property (ld);
  cover property (compare_match[0]);
  cover property (acc & !pwrite & hw & inh);
endmodule
bind tcv_top tcv_monitor MON (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .counter, .capture_event, .compare_event, .compare_match);

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import tcv_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [15:0] counter = '0, a, b;
  logic [5:0]  capture_event = '0, compare_event = '0, compare_match;
  logic [7:0]  hi [6] = '{8'h27, 8'h2A, 8'h2D, 8'h30, 8'h33, 8'h36};
  int          mismatches = 0, checked = 0, cyc = 0;
  logic [31:0] expq [$];
  logic        cmpq [$];
  logic        ev_d = 1'b0;
  always #50 pclk = ~pclk;
  tcv_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .counter, .capture_event, .compare_event, .compare_match);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    if (mismatches == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    expq.push_back({24'h0, e});
    bus(1'b0, idx, 8'h00);
  endtask
  task automatic pulse_cap(input logic [15:0] c);
    @(posedge pclk);
    counter <= c;
    capture_event <= 6'h01;
    @(posedge pclk);
    capture_event <= 6'h00;
  endtask
  task automatic try_cmp(input logic e);
    @(posedge pclk);
    compare_event <= 6'h01;
    cmpq.push_back(e);
    @(posedge pclk);
    compare_event <= 6'h00;
    @(posedge pclk);
  endtask
  // read watcher and hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 2000) begin
      mismatches++;
      close_out();
    end
    if (psel & penable & pready & !pwrite) chk(prdata, expq.pop_front());
    if (psel & penable & pready) chk({31'h0, pslverr}, 32'h0);
    if (presetn & ev_d) chk({26'h0, compare_match}, {31'h0, cmpq.pop_front()});
    else if (presetn) chk({26'h0, compare_match}, 32'h0);
    ev_d = compare_event[0];
  end
  initial begin
    void'($urandom(41656));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int c = 0; c < 6; c++) begin
      a = 16'($urandom);
      bus(1'b1, hi[c], a[15:8]);
      bus(1'b1, hi[c] + 8'h01, a[7:0]);
      rd(hi[c], a[15:8]);
      rd(hi[c] + 8'h01, a[7:0]);
    end
    bus(1'b1, 8'h50, 8'hA5);
    rd(8'h50, 8'h00);
    // capture, then capture held off by a high read
    bus(1'b1, IDX_MODE_BASE, 8'h01);
    rd(IDX_MODE_BASE, 8'h01);
    a = 16'($urandom);
    b = ~a;
    pulse_cap(a);
    rd(hi[0], a[15:8]);
    rd(IDX_INHIBIT_STATUS, 8'h01);
    pulse_cap(b);
    rd(hi[0] + 8'h01, a[7:0]);
    rd(hi[0], a[15:8]);
    rd(hi[0] + 8'h01, a[7:0]);
    pulse_cap(b);
    rd(hi[0], b[15:8]);
    rd(hi[0] + 8'h01, b[7:0]);
    try_cmp(1'b0);
    // compare, then compare held off by a high write
    bus(1'b1, IDX_MODE_BASE, 8'h05);
    bus(1'b1, hi[0], a[15:8]);
    bus(1'b1, hi[0] + 8'h01, a[7:0]);
    counter <= a;
    try_cmp(1'b1);
    bus(1'b1, hi[0], a[15:8]);
    try_cmp(1'b0);
    bus(1'b1, hi[0] + 8'h01, a[7:0]);
    try_cmp(1'b1);
    // buffered compare with the other edge/level bit
    bus(1'b1, IDX_MODE_BASE, 8'h0A);
    try_cmp(1'b1);
    bus(1'b1, hi[0], a[15:8]);
    rd(IDX_INHIBIT_STATUS, 8'h01);
    try_cmp(1'b0);
    bus(1'b1, hi[0] + 8'h01, a[7:0]);
    rd(IDX_INHIBIT_STATUS, 8'h00);
    // value survives a reset
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(hi[0] + 8'h01, a[7:0]);
    rd(hi[0], a[15:8]);
    close_out();
  end
endmodule
